// file: char_lcd_host_interface_test.sv
// bench: host end and display end joined across the link
`timescale 1ns/1ps
`default_nettype none
module char_lcd_host_interface_test;
	logic        sys_clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        we;
	logic        re;
	logic [15:0] rdata;
	logic        busy;
	logic [6:0]  ac_pin;
	logic        wide;
	int          mismatches;
	int          num_checks;
	int          acks = 0;
	int          k;
	logic [7:0]  sh;
	logic        sck_q;
	logic        ack_q;
	logic [7:0]  d [4];
	logic [6:0]  a;
	logic [6:0]  ac;
	logic [15:0] s;
	logic [7:0]  v;
	logic [7:0]  w;
	lcd_link_if lk ();
	lcd_host_end #(.exec_cycles(16'h0014)) i_lcd_host_end (.sys_clk(sys_clk), .rstn(rstn), .link(lk.host),
		.addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata));
	lcd_dev_end #(.exec_cycles(16'h0014), .init_cycles(16'h0014)) i_lcd_dev_end (.sys_clk(sys_clk),
		.rstn(rstn), .link(lk.dev), .internal_op_flag(busy), .addr_counter(ac_pin), .width_select_bit(wide));
	lcd_link_properties i_lcd_link_properties (.sys_clk(sys_clk), .rstn(rstn), .e(lk.e),
		.cmd_data_select(lk.cmd_data_select), .rw(lk.rw), .port_strap_hi(lk.port_strap_hi),
		.port_strap_lo(lk.port_strap_lo), .dev_o(lk.dev_o), .dev_oe(lk.dev_oe), .db(lk.db),
		.internal_op_flag(busy), .addr_counter(ac_pin), .width_select_bit(wide));
	// spi bits taken off the wire itself; i2c acks counted from the display's own sda enable
	always @(posedge sys_clk) begin
		sck_q <= lk.db[lcd_pkg::P_SCK];
		ack_q <= lk.dev_oe[lcd_pkg::P_SDA];
		if (lk.port_strap_hi && !lk.db[lcd_pkg::P_CS] && lk.db[lcd_pkg::P_SCK] && !sck_q) begin
			sh <= {sh[6:0], lk.db[lcd_pkg::P_SDI]};
		end
		if (lk.port_strap_lo && lk.dev_oe[lcd_pkg::P_SDA] && !ack_q) begin
			acks <= acks + 1;
		end
	end
	function automatic logic [6:0] step(input logic [6:0] x, input logic up);
		return up ? x + 7'h01 : x - 7'h01;
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic done(input string n);
		$display("test done: %s", n);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
		@(posedge sys_clk);
		addr <= ad;
		wdata <= dt;
		we <= 1'h1;
		@(posedge sys_clk);
		we <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [15:0] dt);
		@(posedge sys_clk);
		addr <= ad;
		re <= 1'h1;
		@(posedge sys_clk);
		re <= 1'h0;
		#1;
		dt = rdata;
	endtask
	task automatic idle();
		for (int n = 0; n < 3000; n++) begin
			rd(lcd_pkg::REG_STAT, s);
			if (s[8] === 1'h0) begin
				return;
			end
		end
		mismatches++;
		$display("ERROR %0t: host stays active", $time);
		complete_run();
	endtask
	// host polls the busy flag itself before each parallel-mode order except a status read
	task automatic op(input logic rs, input logic rdf, input logic [7:0] b);
		idle();
		wr(lcd_pkg::REG_CMD, {6'h00, rdf, rs, b});
		idle();
	endtask
	task automatic rdx(input logic [7:0] x);
		op(1'h1, 1'h1, 8'h00);
		rd(lcd_pkg::REG_STAT, s);
		chk(s, {8'h00, x});
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 1'h0;
		addr = 8'h00;
		wdata = 16'h0000;
		we = 1'h0;
		re = 1'h0;
		mismatches = 0;
		num_checks = 0;
		void'($urandom(52981));
		repeat (2) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		#1;
		chk({busy, wide, 7'h00, ac_pin}, 16'hC000);
		rd(8'h0C, s);
		chk(s, 16'h0000);
		a = 7'($urandom_range(24, 8));
		op(1'h0, 1'h0, {1'h1, a});
		ac = a;
		for (k = 0; k < 4; k++) begin
			d[k] = 8'($urandom);
			op(1'h1, 1'h0, d[k]);
			ac = step(ac, 1'h1);
		end
		chk({9'h000, ac_pin}, {9'h000, ac});
		op(1'h0, 1'h1, 8'h00);
		rd(lcd_pkg::REG_STAT, s);
		chk(s, {9'h000, ac});
		op(1'h0, 1'h0, {1'h1, a});
		for (k = 0; k < 4; k++) begin
			rdx(d[k]);
		end
		chk({9'h000, ac_pin}, {9'h000, ac});
		done("text memory");
		op(1'h0, 1'h0, {1'h1, a});
		op(1'h1, 1'h0, ~d[0]);
		op(1'h1, 1'h1, 8'h00);
		rdx(d[2]);
		op(1'h0, 1'h0, {1'h1, a});
		op(1'h0, 1'h0, 8'h14);
		rdx(d[1]);
		op(1'h0, 1'h0, 8'h04);
		op(1'h0, 1'h0, {1'h1, 7'(a + 7'h03)});
		op(1'h1, 1'h0, d[3]);
		chk({9'h000, ac_pin}, {9'h000, 7'(a + 7'h02)});
		op(1'h0, 1'h0, 8'h06);
		done("stale read, cursor shift, decrement");
		v = 8'($urandom);
		op(1'h0, 1'h0, 8'h45);
		op(1'h1, 1'h0, v);
		op(1'h0, 1'h0, 8'h45);
		rdx(v);
		op(1'h0, 1'h0, {1'h1, a});
		rdx(~d[0]);
		done("glyph memory");
		op(1'h0, 1'h0, 8'h28);
		chk({15'h0000, wide}, 16'h0000);
		wr(lcd_pkg::REG_CFG, 16'h0000);
		op(1'h0, 1'h0, {1'h1, a});
		op(1'h1, 1'h0, v);
		op(1'h0, 1'h0, {1'h1, a});
		rdx(v);
		op(1'h0, 1'h0, 8'h38);
		wr(lcd_pkg::REG_CFG, 16'h0001);
		chk({15'h0000, wide}, 16'h0001);
		done("nibble mode");
		wr(lcd_pkg::REG_CFG, 16'h0005);
		op(1'h0, 1'h0, 8'hB0);
		w = 8'($urandom);
		op(1'h1, 1'h0, w);
		chk({8'h00, sh}, {8'h00, w});
		chk({9'h000, ac_pin}, 16'h0031);
		k = acks;
		wr(lcd_pkg::REG_CFG, {11'h000, 2'($urandom), 3'h3});
		op(1'h0, 1'h0, 8'hB8);
		op(1'h1, 1'h0, ~w);
		chk(16'(acks - k), 16'h0006);
		chk({9'h000, ac_pin}, 16'h0039);
		wr(lcd_pkg::REG_CFG, 16'h0001);
		op(1'h0, 1'h0, 8'hB0);
		rdx(w);
		op(1'h0, 1'h0, 8'hB8);
		rdx(~w);
		done("serial links");
		@(posedge sys_clk);
		rstn <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		#1;
		chk({busy, wide, 7'h00, ac_pin}, 16'hC000);
		done("second reset");
		complete_run();
	end
endmodule
`default_nettype wire

// file: lcd_dev_end.sv
// display controller end: parallel, spi and i2c receive, memories, busy and address counter
// Contract
// - status read returns busy and counter
// - host waits for busy low
// - data write stores into selected memory
// - counter steps after each write
// - data read returns selected memory byte
// - first read without address set invalid
// - cursor shift reloads output data register
// - counter steps after each read
// - reads only in parallel modes
// - host waits half oscillator before strobe
// - four-bit mode sends two nibbles, high first
// - busy rises after second nibble only
// - straps select parallel, i2c or spi
// - spi uses db5 select, db7 data, db6 clock
// - spi clock idles high, sample rising
// - i2c wiring and width bit set
// - i2c address base plus two straps
// - control byte continuation then data bytes
// - byte kind picks memory or command
// - addressed slave acknowledges every byte
// - start and stop detected on sda
// - busy held through power-on initialization
// - width bit selects eight or four bits
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lcd_dev_end #(
	parameter logic [15:0] exec_cycles = 16'(lcd_pkg::EXEC_CYC),
	parameter logic [15:0] init_cycles = 16'(lcd_pkg::INIT_CYC)
) (
	input  wire logic  sys_clk,
	input  wire logic  rstn,
	lcd_link_if.dev    link,
	output logic       internal_op_flag,
	output logic [6:0] addr_counter,
	output logic       width_select_bit
);
	typedef enum logic [2:0] {
		I_IDLE   = 3'h0,
		I_ADDR   = 3'h1,
		I_CTRL   = 3'h3,
		I_DATA   = 3'h2,
		I_STREAM = 3'h6,
		I_IGNORE = 3'h7
	} i2c_e;

	typedef struct packed {
		logic [1:0]  sy_e;
		logic [1:0]  sy_rs;
		logic [1:0]  sy_rw;
		logic [1:0]  sy_hi;
		logic [1:0]  sy_lo;
		logic [7:0]  db_a;
		logic [7:0]  db_b;
		logic        e_p;
		logic [1:0]  pin_p;
		logic [6:0]  ac;
		logic        glyph;
		logic        incr;
		logic        wide;
		logic        nib_lo;
		logic [3:0]  nib_hi;
		logic [7:0]  dout;
		logic        prefetch;
		logic [15:0] busy_cnt;
		logic        busy;
		logic [7:0]  sh;
		logic [2:0]  bits;
		i2c_e        ist;
		logic        kind;
		logic [1:0]  ackph;
		logic        sda_drv;
		logic [7:0]  d_o;
		logic [7:0]  d_oe;
	} dev_s;

	dev_s       s_q;
	dev_s       s_d;
	logic [7:0] text_mem [0:127];
	logic [7:0] glyph_mem [0:63];
	logic [7:0] mem_rd;
	logic       mem_we;
	logic [7:0] db;
	logic [7:0] ev_b;
	logic [7:0] b;
	logic [7:0] val;
	logic       e;
	logic       spi;
	logic       i2c;
	logic       par;
	logic       ev;
	logic       ev_dat;
	logic       ev_rd;
	logic       rise;
	logic       fall;

	function automatic logic [6:0] step(input logic [6:0] a, input logic up);
		step = up ? a + 7'h01 : a - 7'h01;
	endfunction

	assign mem_rd = s_q.glyph ? glyph_mem[s_q.ac[5:0]] : text_mem[s_q.ac];

	always_comb begin
		s_d = s_q;
		ev = 1'h0;
		ev_dat = 1'h0;
		ev_rd = 1'h0;
		ev_b = 8'h00;
		b = 8'h00;
		val = 8'h00;
		mem_we = 1'h0;
		s_d.sy_e = {s_q.sy_e[0], link.e};
		s_d.sy_rs = {s_q.sy_rs[0], link.cmd_data_select};
		s_d.sy_rw = {s_q.sy_rw[0], link.rw};
		s_d.sy_hi = {s_q.sy_hi[0], link.port_strap_hi};
		s_d.sy_lo = {s_q.sy_lo[0], link.port_strap_lo};
		s_d.db_a = link.db;
		s_d.db_b = s_q.db_a;
		db = s_q.db_b;
		e = s_q.sy_e[1];
		spi = s_q.sy_hi[1];
		i2c = s_q.sy_lo[1] & ~spi;
		par = ~s_q.sy_hi[1] & ~s_q.sy_lo[1];
		s_d.e_p = e;
		s_d.pin_p = db[7:6];
		rise = db[lcd_pkg::P_SCL] & ~s_q.pin_p[1];
		fall = ~db[lcd_pkg::P_SCL] & s_q.pin_p[1];
		if (s_q.busy_cnt != 16'h0000) begin
			s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
		end
		// parallel bus: the falling strobe completes the access
		if (par & ~e & s_q.e_p) begin
			b = s_q.wide ? db : {s_q.nib_hi, db[7:4]};
			if (s_q.wide | s_q.nib_lo) begin
				ev = 1'h1;
				ev_dat = s_q.sy_rs[1];
				ev_rd = s_q.sy_rw[1];
				ev_b = b;
				s_d.nib_lo = 1'h0;
			end else begin
				s_d.nib_hi = db[7:4];
				s_d.nib_lo = 1'h1;
			end
		end
		s_d.d_oe = 8'h00;
		s_d.d_o = 8'h00;
		if (par & e & s_q.sy_rw[1]) begin
			val = s_q.sy_rs[1] ? s_q.dout : {s_q.busy, s_q.ac};
			s_d.d_oe = s_q.wide ? 8'hFF : 8'hF0;
			s_d.d_o = s_q.wide ? val : (s_q.nib_lo ? {val[3:0], 4'h0} : {val[7:4], 4'h0});
		end
		if (spi) begin
			if (db[lcd_pkg::P_CS]) begin
				s_d.bits = 3'h0;
			end else if (db[lcd_pkg::P_SCK] & ~s_q.pin_p[0]) begin
				b = {s_q.sh[6:0], db[lcd_pkg::P_SDI]};
				s_d.sh = b;
				s_d.bits = s_q.bits + 3'h1;
				if (s_q.bits == 3'h7) begin
					ev = 1'h1;
					ev_dat = s_q.sy_rs[1];
					ev_b = b;
				end
			end
		end
		if (!i2c) begin
			s_d.ist = I_IDLE;
			s_d.sda_drv = 1'h0;
			s_d.ackph = 2'h0;
		end else if (db[lcd_pkg::P_SCL] & s_q.pin_p[1] & ~db[lcd_pkg::P_SDA] & s_q.pin_p[0]) begin
			s_d.ist = I_ADDR;
			s_d.bits = 3'h0;
			s_d.ackph = 2'h0;
			s_d.sda_drv = 1'h0;
		end else if (db[lcd_pkg::P_SCL] & s_q.pin_p[1] & db[lcd_pkg::P_SDA] & ~s_q.pin_p[0]) begin
			s_d.ist = I_IDLE;
			s_d.ackph = 2'h0;
			s_d.sda_drv = 1'h0;
		end else if (s_q.ist != I_IDLE) begin
			if (fall && s_q.ackph == 2'h1) begin
				s_d.ackph = 2'h2;
				s_d.sda_drv = (s_q.ist != I_IGNORE);
			end else if (fall && s_q.ackph == 2'h2) begin
				s_d.ackph = 2'h0;
				s_d.sda_drv = 1'h0;
			end else if (rise && s_q.ackph == 2'h0) begin
				b = {s_q.sh[6:0], db[lcd_pkg::P_SDA]};
				s_d.sh = b;
				s_d.bits = s_q.bits + 3'h1;
				if (s_q.bits == 3'h7) begin
					s_d.ackph = 2'h1;
					case (s_q.ist)
						I_ADDR: begin
							// write-only slave: a read address is not ours
							s_d.ist = (b[7:1] == {lcd_pkg::I2C_BASE, db[1:0]} && !b[0]) ? I_CTRL : I_IGNORE;
						end
						I_CTRL: begin
							s_d.kind = b[6];
							s_d.ist = b[7] ? I_DATA : I_STREAM;
						end
						I_DATA, I_STREAM: begin
							ev = 1'h1;
							ev_dat = s_q.kind;
							ev_b = b;
							if (s_q.ist == I_DATA) begin
								s_d.ist = I_CTRL;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
		if (s_q.sda_drv) begin
			s_d.d_oe[lcd_pkg::P_SDA] = 1'h1;
		end
		// the output register trails the counter by one cycle
		if (s_q.prefetch) begin
			s_d.dout = mem_rd;
			s_d.prefetch = 1'h0;
		end
		if (ev) begin
			if (!(ev_rd & ~ev_dat)) begin
				s_d.busy_cnt = exec_cycles;
			end
			if (ev_dat & ev_rd) begin
				s_d.ac = step(s_q.ac, s_q.incr);
				s_d.prefetch = 1'h1;
			end else if (ev_dat) begin
				mem_we = 1'h1;
				s_d.ac = step(s_q.ac, s_q.incr);
			end else if (!ev_rd) begin
				casez (ev_b)
					8'b1???????: begin
						s_d.ac = ev_b[6:0];
						s_d.glyph = 1'h0;
						s_d.prefetch = 1'h1;
					end
					8'b01??????: begin
						s_d.ac = {1'h0, ev_b[5:0]};
						s_d.glyph = 1'h1;
						s_d.prefetch = 1'h1;
					end
					8'b001?????: begin
						s_d.wide = ev_b[4];
					end
					8'b0001????: begin
						if (!ev_b[3]) begin
							s_d.ac = step(s_q.ac, ev_b[2]);
							s_d.prefetch = 1'h1;
						end
					end
					8'b000001??: begin
						s_d.incr = ev_b[1];
					end
					8'b0000001?: begin
						s_d.ac = 7'h00;
						s_d.glyph = 1'h0;
					end
					8'b00000001: begin
						s_d.ac = 7'h00;
						s_d.glyph = 1'h0;
						s_d.incr = 1'h1;
					end
					default: begin
					end
				endcase
			end
		end
		s_d.busy = (s_d.busy_cnt != 16'h0000);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.busy_cnt <= init_cycles;
			s_q.busy <= 1'h1;
			s_q.wide <= lcd_pkg::RST_WIDE;
			s_q.incr <= lcd_pkg::RST_INCR;
		end else begin
			s_q <= s_d;
		end
	end

	// memories carry no reset; contents are undefined until written
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			if (s_q.glyph) begin
				glyph_mem[s_q.ac[5:0]] <= ev_b;
			end else begin
				text_mem[s_q.ac] <= ev_b;
			end
		end
	end

	assign link.dev_o = s_q.d_o;
	assign link.dev_oe = s_q.d_oe;
	assign internal_op_flag = s_q.busy;
	assign addr_counter = s_q.ac;
	assign width_select_bit = s_q.wide;
endmodule
`default_nettype wire

// file: lcd_host_end.sv
// host end: register port orders parallel strobes, spi or i2c writes
`timescale 1ns/1ps
`default_nettype none
module lcd_host_end #(
	parameter logic [15:0] exec_cycles = 16'(lcd_pkg::EXEC_CYC)
) (
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	lcd_link_if.host    link,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        we,
	input  wire logic        re,
	output logic [15:0]      rdata
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_POLL = 3'h1,
		H_GAP  = 3'h3,
		H_XFER = 3'h2,
		H_SER  = 3'h6,
		H_WAIT = 3'h7
	} hst_e;

	typedef struct packed {
		logic [7:0]  dba;
		logic [7:0]  dbb;
		logic        wide;
		logic        s_lo;
		logic        s_hi;
		logic [1:0]  astr;
		logic [7:0]  byte_v;
		logic        op_rs;
		logic        op_rd;
		logic        cur_rs;
		logic        cur_rd;
		hst_e        st;
		logic [15:0] cnt;
		logic [1:0]  ph;
		logic        nib;
		logic [7:0]  rdat;
		logic [5:0]  slot;
		logic [26:0] sh;
		logic        e;
		logic        rs;
		logic        rw;
		logic [7:0]  ho;
		logic [7:0]  hoe;
		logic [15:0] rdata;
	} host_s;

	host_s      h_q;
	host_s      h_d;
	logic       serial;
	logic       i2c;
	logic       clk;
	logic       dat;
	logic       cs;
	logic [5:0] nb2;
	logic [5:0] bidx;

	always_comb begin
		h_d = h_q;
		h_d.dba = link.db;
		h_d.dbb = h_q.dba;
		h_d.rdata = 16'h0000;
		serial = h_q.s_hi | h_q.s_lo;
		i2c = h_q.s_lo & ~h_q.s_hi;
		nb2 = i2c ? lcd_pkg::I2C_LAST_BIT_SLOT : lcd_pkg::SPI_LAST_BIT_SLOT;
		bidx = 6'((h_q.slot - 6'h01) >> 1);
		if (re) begin
			case (addr)
				lcd_pkg::REG_CMD:  h_d.rdata = {6'h00, h_q.op_rd, h_q.op_rs, h_q.byte_v};
				lcd_pkg::REG_STAT: h_d.rdata = {7'h00, h_q.st != H_IDLE, h_q.rdat};
				lcd_pkg::REG_CFG:  h_d.rdata = {11'h000, h_q.astr, h_q.s_hi, h_q.s_lo, h_q.wide};
				default:           h_d.rdata = 16'h0000;
			endcase
		end
		case (h_q.st)
			H_IDLE: begin
				h_d.e = 1'h0;
				if (we && addr == lcd_pkg::REG_CFG) begin
					h_d.wide = wdata[lcd_pkg::CFG_WIDE];
					h_d.s_lo = wdata[lcd_pkg::CFG_LO];
					h_d.s_hi = wdata[lcd_pkg::CFG_HI];
					h_d.astr = wdata[lcd_pkg::CFG_SA +: 2];
				end
				if (we && addr == lcd_pkg::REG_CMD) begin
					h_d.byte_v = wdata[7:0];
					h_d.op_rs = wdata[lcd_pkg::CMD_RS];
					h_d.op_rd = wdata[lcd_pkg::CMD_RD] & ~serial;
					h_d.rs = wdata[lcd_pkg::CMD_RS];
					h_d.ph = 2'h0;
					h_d.nib = 1'h0;
					h_d.cnt = 16'(lcd_pkg::AS_CYC - 1);
					h_d.cur_rs = 1'h0;
					h_d.cur_rd = 1'h1;
					if (serial) begin
						h_d.st = H_SER;
						h_d.slot = 6'h00;
						h_d.cnt = 16'(lcd_pkg::SER_HALF_CYC - 1);
						// i2c: address, control with last-control mark, data; ack slots released
						h_d.sh = i2c ? {lcd_pkg::I2C_BASE, h_q.astr, 1'h0, 1'h1, 1'h0, wdata[lcd_pkg::CMD_RS], 6'h00,
							1'h1, wdata[7:0], 1'h1} : {wdata[7:0], 19'h00000};
					end else if (!wdata[lcd_pkg::CMD_RS] && wdata[lcd_pkg::CMD_RD]) begin
						h_d.st = H_XFER;
					end else begin
						h_d.st = H_POLL;
					end
				end
			end
			H_POLL, H_XFER: begin
				h_d.rs = h_q.cur_rs;
				h_d.rw = h_q.cur_rd;
				h_d.hoe = h_q.cur_rd ? 8'h00 : (h_q.wide ? 8'hFF : 8'hF0);
				h_d.ho = h_q.wide ? h_q.byte_v : (h_q.nib ? {h_q.byte_v[3:0], 4'h0} : {h_q.byte_v[7:4], 4'h0});
				if (h_q.cnt != 16'h0000) begin
					h_d.cnt = h_q.cnt - 16'h0001;
				end else begin
					case (h_q.ph)
						2'h0: begin
							h_d.ph = 2'h1;
							h_d.e = 1'h1;
							h_d.cnt = 16'(lcd_pkg::PW_CYC - 1);
						end
						2'h1: begin
							if (h_q.wide) begin
								h_d.rdat = h_q.dbb;
							end else if (h_q.nib) begin
								h_d.rdat[3:0] = h_q.dbb[7:4];
							end else begin
								h_d.rdat[7:4] = h_q.dbb[7:4];
							end
							h_d.ph = 2'h2;
							h_d.e = 1'h0;
							h_d.cnt = 16'(lcd_pkg::TAIL_CYC - 1);
						end
						default: begin
							h_d.ph = 2'h0;
							h_d.cnt = 16'(lcd_pkg::AS_CYC - 1);
							if (!(h_q.wide | h_q.nib)) begin
								h_d.nib = 1'h1;
							end else if (h_q.st == H_XFER) begin
								h_d.st = H_IDLE;
								h_d.hoe = 8'h00;
							end else if (!h_q.rdat[lcd_pkg::P_BUSY]) begin
								h_d.st = H_GAP;
								h_d.cnt = 16'(lcd_pkg::OSC_HALF_CYC - 1);
							end else begin
								h_d.nib = 1'h0;
							end
						end
					endcase
				end
			end
			H_GAP: begin
				if (h_q.cnt != 16'h0000) begin
					h_d.cnt = h_q.cnt - 16'h0001;
				end else begin
					h_d.cur_rs = h_q.op_rs;
					h_d.cur_rd = h_q.op_rd;
					h_d.st = H_XFER;
					h_d.ph = 2'h0;
					h_d.nib = 1'h0;
					h_d.cnt = 16'(lcd_pkg::AS_CYC - 1);
				end
			end
			H_SER: begin
				if (h_q.cnt != 16'h0000) begin
					h_d.cnt = h_q.cnt - 16'h0001;
				end else if (h_q.slot == nb2 + 6'h03) begin
					// serial links cannot read busy, so wait out the execution time
					h_d.st = H_WAIT;
					h_d.cnt = exec_cycles;
				end else begin
					h_d.slot = h_q.slot + 6'h01;
					h_d.cnt = 16'(lcd_pkg::SER_HALF_CYC - 1);
				end
			end
			H_WAIT: begin
				if (h_q.cnt != 16'h0000) begin
					h_d.cnt = h_q.cnt - 16'h0001;
				end else begin
					h_d.st = H_IDLE;
				end
			end
			default: begin
				h_d.st = H_IDLE;
			end
		endcase
		clk = 1'h1;
		dat = 1'h1;
		cs = 1'h1;
		if (h_q.st == H_SER) begin
			clk = (h_q.slot == 6'h00) || (h_q.slot > nb2 + 6'h01) || (h_q.slot <= nb2 && !h_q.slot[0]);
			// spi clock stays at its idle level once select is raised
			clk = clk || (!i2c && h_q.slot > nb2);
			dat = (h_q.slot != 6'h00) && ((h_q.slot <= nb2) ? h_q.sh[5'(6'h1A - bidx)] : (h_q.slot == nb2 + 6'h03));
			cs = h_q.slot > nb2;
		end
		if (i2c) begin
			h_d.ho = {clk, 1'h0, 1'h0, 3'h0, h_q.astr};
			h_d.hoe = {1'h1, ~dat, 1'h1, 3'h0, 2'h3};
		end else if (serial) begin
			h_d.ho = {dat, clk, cs, 5'h00};
			h_d.hoe = 8'hE0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			h_q <= '0;
			h_q.wide <= lcd_pkg::RST_WIDE;
		end else begin
			h_q <= h_d;
		end
	end

	assign link.e = h_q.e;
	assign link.cmd_data_select = h_q.rs;
	assign link.rw = h_q.rw;
	assign link.port_strap_hi = h_q.s_hi;
	assign link.port_strap_lo = h_q.s_lo;
	assign link.host_o = h_q.ho;
	assign link.host_oe = h_q.hoe;
	assign rdata = h_q.rdata;
endmodule
`default_nettype wire

// file: lcd_host_end_note_placeholder.sv
// intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: lcd_link_if.sv
// pins between the host and the display controller, with wired-and resolution
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
	logic       e;
	logic       cmd_data_select;
	logic       rw;
	logic       port_strap_hi;
	logic       port_strap_lo;
	logic [7:0] host_o;
	logic [7:0] host_oe;
	logic [7:0] dev_o;
	logic [7:0] dev_oe;
	logic [7:0] db;
	// undriven lines float high through the pull-ups
	assign db = ~((host_oe & ~host_o) | (dev_oe & ~dev_o));
	modport host (output e, cmd_data_select, rw, port_strap_hi, port_strap_lo, host_o, host_oe, input db);
	modport dev (input e, cmd_data_select, rw, port_strap_hi, port_strap_lo, db, output dev_o, dev_oe);
endinterface
`default_nettype wire

// file: lcd_link_properties.sv
// timing and drive checks on the pins between host end and display end
`timescale 1ns/1ps
`default_nettype none
module lcd_link_properties (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       e,
	input wire logic       cmd_data_select,
	input wire logic       rw,
	input wire logic       port_strap_hi,
	input wire logic       port_strap_lo,
	input wire logic [7:0] dev_o,
	input wire logic [7:0] dev_oe,
	input wire logic [7:0] db,
	input wire logic       internal_op_flag,
	input wire logic [6:0] addr_counter,
	input wire logic       width_select_bit
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic par;
	logic spi;
	logic i2c;
	assign par = !port_strap_hi && !port_strap_lo;
	assign spi = port_strap_hi;
	assign i2c = port_strap_lo && !port_strap_hi;
	property p_init_busy;
		$rose(rstn) |-> internal_op_flag [*8];
	endproperty
	a_init_busy: assert property (p_init_busy) else $error("busy low during init");
	// sync delay is a few cycles, strobe is far longer than eight
	property p_status_drive;
		par && width_select_bit && !cmd_data_select && rw && $rose(e) |-> ##8 (dev_oe[7] && db[6:0] == addr_counter);
	endproperty
	a_status_drive: assert property (p_status_drive) else $error("status read not on lines");
	property p_nibble_lines;
		par && !width_select_bit |-> dev_oe[3:0] == 4'h0;
	endproperty
	a_nibble_lines: assert property (p_nibble_lines) else $error("low lines driven in nibble mode");
	property p_serial_no_read;
		spi |-> dev_oe == 8'h00;
	endproperty
	a_serial_no_read: assert property (p_serial_no_read) else $error("device drives in spi mode");
	property p_i2c_pins;
		i2c |-> (dev_oe & 8'hBF) == 8'h00;
	endproperty
	a_i2c_pins: assert property (p_i2c_pins) else $error("device drives a line other than sda");
	property p_ack_start;
		i2c && $rose(dev_oe[6]) |-> !db[7] && !dev_o[6];
	endproperty
	a_ack_start: assert property (p_ack_start) else $error("ack not low or not begun with scl low");
	property p_spi_idle_high;
		spi && $past(port_strap_hi, 4) && $rose(db[5]) |-> db[6] [*4];
	endproperty
	a_spi_idle_high: assert property (p_spi_idle_high) else $error("serial clock not idle high");
	property p_spi_hold_low;
		spi && !db[5] && !db[6] && !$past(db[6]) |-> $stable(db[7]);
	endproperty
	a_spi_hold_low: assert property (p_spi_hold_low) else $error("serial data moved while clock low");
	c_status: cover property (par && !cmd_data_select && rw && $rose(e));
	c_spi_frame: cover property (spi && $fell(db[5]));
	c_ack: cover property (i2c && $rose(dev_oe[6]));
endmodule
`default_nettype wire

// file: lcd_pkg.sv
// shared constants for the character display host link, both ends
package lcd_pkg;
	localparam int CLK_NS       = 4;
	localparam int EXEC_NS      = 18500;
	localparam int EXEC_CYC     = (EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int INIT_CYC     = 1000;
	localparam int OSC_HALF_CYC = 1;
	localparam int AS_NS        = 60;
	localparam int PW_NS        = 450;
	localparam int CYC_NS       = 1000;
	localparam int AS_CYC       = (AS_NS + CLK_NS - 1) / CLK_NS;
	localparam int PW_CYC       = (PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int TAIL_CYC     = (CYC_NS - PW_NS - AS_NS + CLK_NS - 1) / CLK_NS;
	// long enough that the display's synchronised ack is on sda before scl rises
	localparam int SER_HALF_CYC = 8;
	localparam logic [4:0] I2C_BASE = 5'h0F;
	localparam int P_CS   = 5;
	localparam int P_SCK  = 6;
	localparam int P_SDI  = 7;
	localparam int P_SDA  = 6;
	localparam int P_SCL  = 7;
	localparam int P_BUSY = 7;
	localparam logic RST_WIDE = 1'h1;
	localparam logic RST_INCR = 1'h1;
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CFG  = 8'h08;
	localparam int CMD_RS  = 8;
	localparam int CMD_RD  = 9;
	localparam int CFG_WIDE = 0;
	localparam int CFG_LO   = 1;
	localparam int CFG_HI   = 2;
	localparam int CFG_SA   = 3;
	localparam logic [5:0] I2C_LAST_BIT_SLOT = 6'h36;
	localparam logic [5:0] SPI_LAST_BIT_SLOT = 6'h10;
endpackage
